/* File: rtl/crb_map.vh */
/*
 Register map, field positions and reset values of the CAN receive steering block.
 Assumes a 32-bit Avalon-MM slave with byte addressing; 16-bit registers in the low half.
*/
`ifndef CRB_MAP_VH
`define CRB_MAP_VH

`define CRB_ADDR_W          6
`define CRB_OFF_FIFO_CTRL   6'h00
`define CRB_OFF_PTR_4_7     6'h04
`define CRB_OFF_PTR_8_11    6'h08
`define CRB_OFF_MASK0_SID   6'h0C
`define CRB_OFF_MASK0_EID   6'h10
`define CRB_OFF_MASK1_SID   6'h14
`define CRB_OFF_MASK1_EID   6'h18
`define CRB_OFF_MASK2_SID   6'h1C
`define CRB_OFF_MASK2_EID   6'h20
`define CRB_OFF_STATUS      6'h24
`define CRB_OFF_STEER       6'h28

`define CRB_SIZE_LSB        13
`define CRB_SIZE_MSB        15
`define CRB_FSA_LSB         0
`define CRB_FSA_MSB         4
`define CRB_FCTRL_WMASK     16'hE01F
`define CRB_SID_WMASK       16'hFFEB
`define CRB_SIZE_RESERVED   3'h7
`define CRB_PTR_FIFO        4'hF

`define CRB_RST_FIFO_CTRL   16'h0000
`define CRB_RST_PTR         16'h0000
`define CRB_RST_MASK        16'h0000

`define CRB_RSP_LAT         1

`endif

/* File: rtl/crb_match.v */
/*
 Masked identifier compare for one acceptance mask against one filter.
 Assumes identifier and filter fields are presented in the mask register layout.
*/
`timescale 1ns/1ps
`include "crb_map.vh"
module crb_match (
    input  wire [15:0] mask_sid,
    input  wire [15:0] mask_eid,
    input  wire [15:0] id_sid,
    input  wire [15:0] id_eid,
    input  wire [15:0] flt_sid,
    input  wire [15:0] flt_eid,
    output wire        hit
);
    wire [15:0] sid_diff;
    wire [15:0] eid_diff;
    // Only the identifier bits and the kind-select bit take part
    assign sid_diff = (id_sid ^ flt_sid) & mask_sid & `CRB_SID_WMASK;
    assign eid_diff = (id_eid ^ flt_eid) & mask_eid;
    assign hit = ~|sid_diff & ~|eid_diff;
endmodule

/* File: rtl/crb_steer.v */
/*
 Maps one filter hit to a destination buffer from the pointer registers.
 Assumes filter index and pointers are stable in the cycle of the hit.
*/
`timescale 1ns/1ps
`include "crb_map.vh"
module crb_steer (
    input  wire [15:0] ptr_4_7,
    input  wire [15:0] ptr_8_11,
    input  wire [3:0]  filter_index,
    input  wire [4:0]  fifo_first_buffer,
    output reg         dest_valid,
    output reg         dest_is_fifo,
    output reg  [4:0]  dest_buffer
);
    reg [3:0] code;
    always @* begin
        code = 4'h0;
        dest_valid = 1'b1;
        case (filter_index)
            4'h4: code = ptr_4_7[3:0];
            4'h5: code = ptr_4_7[7:4];
            4'h6: code = ptr_4_7[11:8];
            4'h7: code = ptr_4_7[15:12];
            4'h8: code = ptr_8_11[3:0];
            4'h9: code = ptr_8_11[7:4];
            4'hA: code = ptr_8_11[11:8];
            4'hB: code = ptr_8_11[15:12];
            default: dest_valid = 1'b0;
        endcase
        dest_is_fifo = (code == `CRB_PTR_FIFO);
        // FIFO hits land at the FIFO start buffer
        dest_buffer = dest_is_fifo ? fifo_first_buffer : {1'b0, code};
    end
endmodule

/* File: rtl/crb_top.v */
/*
 CAN receive steering configuration: FIFO control, filter pointers and masks.
 Assumes an Avalon-MM master that holds each request until waitrequest is low.
*/
`timescale 1ns/1ps
`include "crb_map.vh"
module crb_top (
    input  wire                   clk,
    input  wire                   rst,
    input  wire [`CRB_ADDR_W-1:0] avs_address,
    input  wire                   avs_read,
    input  wire                   avs_write,
    input  wire [31:0]            avs_writedata,
    input  wire [3:0]             avs_byteenable,
    output reg  [31:0]            avs_readdata,
    output wire                   avs_waitrequest,
    input  wire                   hit_valid,
    input  wire [3:0]             hit_filter,
    input  wire [1:0]             hit_mask_sel,
    input  wire [15:0]            id_sid,
    input  wire [15:0]            id_eid,
    input  wire [15:0]            flt_sid,
    input  wire [15:0]            flt_eid,
    output reg                    dest_valid,
    output reg                    dest_is_fifo,
    output reg  [4:0]             dest_buffer,
    output reg                    id_match,
    output reg  [5:0]             ram_buffer_total,
    output reg                    size_reserved
);
    reg  [15:0] fifo_control;
    reg  [15:0] ptr_4_7;
    reg  [15:0] ptr_8_11;
    reg  [15:0] mask_sid [0:2];
    reg  [15:0] mask_eid [0:2];
    reg         ack;
    reg  [4:0]  last_dest;
    reg         last_fifo;
    wire        req;
    wire [15:0] wmask;
    wire [2:0]  ram_buffer_count;
    wire [4:0]  fifo_first_buffer;
    wire        st_valid;
    wire        st_fifo;
    wire [4:0]  st_buf;
    wire [2:0]  m_hit;
    reg  [5:0]  next_total;
    reg         sel_hit;

    // Lane mask over the low half; upper lanes ignored
    assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign req = avs_read | avs_write;
    // One wait cycle, so read data come from a flop
    assign avs_waitrequest = req & ~ack;

    assign ram_buffer_count  = fifo_control[`CRB_SIZE_MSB:`CRB_SIZE_LSB];
    assign fifo_first_buffer = fifo_control[`CRB_FSA_MSB:`CRB_FSA_LSB];

    function [15:0] merge;
        input [15:0] old;
        input [15:0] data;
        input [15:0] lanes;
        input [15:0] keep;
        begin
            merge = ((old & ~lanes) | (data & lanes)) & keep;
        end
    endfunction

    function is_mask_sid;
        input [`CRB_ADDR_W-1:0] a;
        input integer           n;
        begin
            is_mask_sid = (a == (`CRB_OFF_MASK0_SID + {n[1:0], 3'b000}));
        end
    endfunction

    function is_mask_eid;
        input [`CRB_ADDR_W-1:0] a;
        input integer           n;
        begin
            is_mask_eid = (a == (`CRB_OFF_MASK0_EID + {n[1:0], 3'b000}));
        end
    endfunction

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fifo_control <= `CRB_RST_FIFO_CTRL;
            ptr_4_7      <= `CRB_RST_PTR;
            ptr_8_11     <= `CRB_RST_PTR;
        end else if (avs_write & ack) begin
            // Commit only when the wait ends, as the master sees it
            case (avs_address)
                `CRB_OFF_FIFO_CTRL:
                    fifo_control <= merge(fifo_control, avs_writedata[15:0], wmask,
                                          `CRB_FCTRL_WMASK);
                `CRB_OFF_PTR_4_7:
                    ptr_4_7 <= merge(ptr_4_7, avs_writedata[15:0], wmask, 16'hFFFF);
                `CRB_OFF_PTR_8_11:
                    ptr_8_11 <= merge(ptr_8_11, avs_writedata[15:0], wmask, 16'hFFFF);
                default: begin
                end
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_mask
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    mask_sid[g] <= `CRB_RST_MASK;
                    mask_eid[g] <= `CRB_RST_MASK;
                end else if (avs_write & ack) begin
                    if (is_mask_sid(avs_address, g))
                        mask_sid[g] <= merge(mask_sid[g], avs_writedata[15:0], wmask,
                                             `CRB_SID_WMASK);
                    if (is_mask_eid(avs_address, g))
                        mask_eid[g] <= merge(mask_eid[g], avs_writedata[15:0], wmask,
                                             16'hFFFF);
                end
            end
            crb_match u_match (
                .mask_sid (mask_sid[g]),
                .mask_eid (mask_eid[g]),
                .id_sid   (id_sid),
                .id_eid   (id_eid),
                .flt_sid  (flt_sid),
                .flt_eid  (flt_eid),
                .hit      (m_hit[g])
            );
        end
    endgenerate

    always @* begin
        case (ram_buffer_count)
            3'h0: next_total = 6'd4;
            3'h1: next_total = 6'd6;
            3'h2: next_total = 6'd8;
            3'h3: next_total = 6'd12;
            3'h4: next_total = 6'd16;
            3'h5: next_total = 6'd24;
            3'h6: next_total = 6'd32;
            // Reserved code: report no buffers rather than guess
            default: next_total = 6'd0;
        endcase
        case (hit_mask_sel)
            2'h0: sel_hit = m_hit[0];
            2'h1: sel_hit = m_hit[1];
            2'h2: sel_hit = m_hit[2];
            default: sel_hit = 1'b0;
        endcase
    end

    crb_steer u_steer (
        .ptr_4_7           (ptr_4_7),
        .ptr_8_11          (ptr_8_11),
        .filter_index      (hit_filter),
        .fifo_first_buffer (fifo_first_buffer),
        .dest_valid        (st_valid),
        .dest_is_fifo      (st_fifo),
        .dest_buffer       (st_buf)
    );

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dest_valid       <= 1'b0;
            dest_is_fifo     <= 1'b0;
            dest_buffer      <= 5'h00;
            id_match         <= 1'b0;
            ram_buffer_total <= 6'd0;
            size_reserved    <= 1'b0;
            last_dest        <= 5'h00;
            last_fifo        <= 1'b0;
        end else begin
            dest_valid       <= hit_valid & st_valid;
            dest_is_fifo     <= st_fifo;
            dest_buffer      <= st_buf;
            id_match         <= hit_valid & sel_hit;
            ram_buffer_total <= next_total;
            size_reserved    <= (ram_buffer_count == `CRB_SIZE_RESERVED);
            if (hit_valid & st_valid) begin
                last_dest <= st_buf;
                last_fifo <= st_fifo;
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack) begin
            case (avs_address)
                `CRB_OFF_FIFO_CTRL: avs_readdata <= {16'h0000, fifo_control};
                `CRB_OFF_PTR_4_7:   avs_readdata <= {16'h0000, ptr_4_7};
                `CRB_OFF_PTR_8_11:  avs_readdata <= {16'h0000, ptr_8_11};
                `CRB_OFF_MASK0_SID: avs_readdata <= {16'h0000, mask_sid[0]};
                `CRB_OFF_MASK0_EID: avs_readdata <= {16'h0000, mask_eid[0]};
                `CRB_OFF_MASK1_SID: avs_readdata <= {16'h0000, mask_sid[1]};
                `CRB_OFF_MASK1_EID: avs_readdata <= {16'h0000, mask_eid[1]};
                `CRB_OFF_MASK2_SID: avs_readdata <= {16'h0000, mask_sid[2]};
                `CRB_OFF_MASK2_EID: avs_readdata <= {16'h0000, mask_eid[2]};
                `CRB_OFF_STATUS:
                    avs_readdata <= {25'h0000000, size_reserved, ram_buffer_total};
                `CRB_OFF_STEER:
                    avs_readdata <= {26'h0000000, last_fifo, last_dest};
                // Unmapped offsets read zero, writes dropped
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

/* File: tb/can_rx_buffer_steering_test.sv */
/* Testbench for crb_top: register access over Avalon and steering.
 Assumes the far-side model and the bound checker. */
`timescale 1ns/1ps
`include "crb_map.vh"
module can_rx_buffer_steering_test;
    logic        clk = 0, rst = 1, avs_read = 0, avs_write = 0, v;
    logic [5:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0;
    logic [3:0]  avs_byteenable = 0;
    logic [15:0] rd, p;
    logic [4:0]  fs;
    logic [5:0]  tot [8] = '{6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20, 6'h00};
    wire  [31:0] avs_readdata;
    wire  [15:0] id_sid, id_eid, flt_sid, flt_eid;
    wire  [5:0]  ram_buffer_total;
    wire  [4:0]  dest_buffer;
    wire  [3:0]  hit_filter;
    wire  [1:0]  hit_mask_sel;
    wire         avs_waitrequest, hit_valid, dest_valid, dest_is_fifo, id_match, size_reserved;
    int          num_errors = 0, check_count = 0, i, j;
    crb_top i_dut (.*);
    crb_can_far i_far (.*);
    initial forever #4 clk = ~clk;
    task print_verdict;
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One idle cycle after each access keeps a strobe from moving twice in one step
    task bus(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'hFFFF, d};
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) chk(16'hDEAD, 16'h0000);
        rd = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [5:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task rdx(input logic [5:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000, 4'hF);
        chk(rd, e);
    endtask
    task hit(input logic [3:0] f, input logic [1:0] m, input logic [15:0] ie,
             input logic [15:0] fe, input logic [7:0] e, input logic [7:0] mk);
        i_far.send(i % 2, f, m, ie, fe);
        #1;
        chk({8'h00, mk & {id_match, dest_valid, dest_is_fifo, dest_buffer}}, {8'h00, e & mk});
        // Back on the rising edge so the next stimulus is not launched off-edge
        @(posedge clk);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        chk(16'hDEAD, 16'h0000);
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 9; i++) rdx(6'(4 * i), 16'h0000);
        wr(6'h2C, 16'hFFFF);
        rdx(6'h2C, 16'h0000);
        for (i = 0; i < 8; i++) begin
            wr(`CRB_OFF_FIFO_CTRL, {i[2:0], 13'h1FFF});
            rdx(`CRB_OFF_FIFO_CTRL, {i[2:0], 8'h00, 5'h1F});
            chk({9'h000, size_reserved, ram_buffer_total}, {9'h000, i == 7, tot[i]});
        end
        rdx(`CRB_OFF_STATUS, 16'h0040);
        wr(`CRB_OFF_PTR_4_7, 16'hF0E1);
        wr(`CRB_OFF_PTR_8_11, 16'h2F00);
        bus(1'b1, `CRB_OFF_PTR_8_11, 16'hAA3E, 4'h1);
        rdx(`CRB_OFF_PTR_4_7, 16'hF0E1);
        rdx(`CRB_OFF_PTR_8_11, 16'h2F3E);
        for (j = 0; j < 2; j++) begin
            fs = j ? 5'h1F : 5'h00;
            wr(`CRB_OFF_FIFO_CTRL, {11'h000, fs});
            for (i = 3; i < 13; i++) begin
                p = (i < 8 ? 16'hF0E1 : 16'h2F3E) >> (4 * (i % 4));
                v = i > 3 && i < 12;
                hit(i[3:0], 2'h1, 16'h0000, 16'h0000, {1'b1, v, p[3:0] == 4'hF,
                    p[3:0] == 4'hF ? fs : {1'b0, p[3:0]}}, v ? 8'hFF : 8'hC0);
            end
        end
        wr(`CRB_OFF_MASK0_SID, 16'hFFFF);
        rdx(`CRB_OFF_MASK0_SID, 16'hFFEB);
        wr(`CRB_OFF_MASK0_EID, 16'h00FF);
        rdx(`CRB_OFF_MASK0_EID, 16'h00FF);
        hit(4'h2, 2'h0, 16'h00A5, 16'hFFA5, 8'h80, 8'hC0);
        hit(4'h2, 2'h0, 16'h00A5, 16'h00A4, 8'h00, 8'hC0);
        hit(4'h2, 2'h3, 16'h00A5, 16'h00A5, 8'h00, 8'hC0);
        hit(4'h2, 2'h2, 16'h00A5, 16'h5A5A, 8'h80, 8'hC0);
        print_verdict;
    end
endmodule

/* File: tb/crb_can_far.sv */
/* Far-side model: protocol engine offering accepted messages.
 Assumes the caller steps it just after a rising edge. */
`timescale 1ns/1ps
module crb_can_far (
    input  logic        clk,
    output logic        hit_valid,
    output logic [3:0]  hit_filter,
    output logic [1:0]  hit_mask_sel,
    output logic [15:0] id_sid,
    output logic [15:0] id_eid,
    output logic [15:0] flt_sid,
    output logic [15:0] flt_eid
);
    initial {hit_valid, hit_filter, hit_mask_sel, id_sid, id_eid, flt_sid, flt_eid} = '0;
    // Stale filter, mask-select and EID fields are inverted so a design never relies on them; the SID fields stay 1234
    task send(input int g, input logic [3:0] f, input logic [1:0] m,
              input logic [15:0] ie, input logic [15:0] fe);
        repeat (g) @(posedge clk);
        hit_valid <= 1'b1;
        {hit_filter, hit_mask_sel, id_sid, id_eid, flt_sid, flt_eid} <=
            {f, m, 16'h1234, ie, 16'h1234, fe};
        @(posedge clk);
        hit_valid <= 1'b0;
        {hit_filter, hit_mask_sel, id_eid, flt_eid} <= ~{f, m, ie, fe};
    endtask
endmodule

/* File: tb/crb_top_sva.sv */
/* Port assertions for crb_top.
 Assumes one clock and an async active-high reset. */
`timescale 1ns/1ps
module crb_top_sva (
    input logic        clk,
    input logic        rst,
    input logic        avs_read,
    input logic        avs_write,
    input logic        avs_waitrequest,
    input logic        hit_valid,
    input logic [3:0]  hit_filter,
    input logic [1:0]  hit_mask_sel,
    input logic [15:0] id_sid,
    input logic [15:0] id_eid,
    input logic [15:0] flt_sid,
    input logic [15:0] flt_eid,
    input logic        dest_valid,
    input logic        dest_is_fifo,
    input logic [4:0]  dest_buffer,
    input logic        id_match,
    input logic [5:0]  ram_buffer_total,
    input logic        size_reserved
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_steer;
        hit_valid && hit_filter >= 4'h4 && hit_filter <= 4'hB;
    endsequence
    sequence s_same;
        hit_valid && hit_mask_sel != 2'h3 && id_sid == flt_sid && id_eid == flt_eid;
    endsequence
    AST_STEER_HIT: assert property (s_steer |=> dest_valid) else $error("steer missed");
    AST_STEER_SKIP: assert property (hit_valid && (hit_filter < 4'h4 || hit_filter > 4'hB)
        |=> !dest_valid) else $error("unsteered filter gave dest");
    AST_QUIET: assert property (!hit_valid |=> !dest_valid && !id_match)
        else $error("output without hit");
    AST_FIXED_BUF: assert property (dest_valid && !dest_is_fifo |-> dest_buffer <= 5'h0E)
        else $error("fixed buffer above 14");
    AST_SAME_ID: assert property (s_same |=> id_match) else $error("equal id missed");
    AST_NO_MASK: assert property (hit_valid && hit_mask_sel == 2'h3 |=> !id_match)
        else $error("mask 3 matched");
    AST_RSV_SIZE: assert property (size_reserved |-> ram_buffer_total == 6'h00)
        else $error("reserved size not 0");
    AST_SIZE_SET: assert property (!size_reserved && !$past(rst) |-> ram_buffer_total inside
        {6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20}) else $error("bad buffer total");
    AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("second wait cycle");
endmodule
bind crb_top crb_top_sva i_sva (.*);
